// ===== rtl/ppp_cfg.svh
// constants of the parallel programming port: command codes, geometry, timing
// assumes a 200 MHz core clock; included by its bare name from the port module only
//
// Operation
// [RL1] flash: 128 pages of 64 words
// [RL2] eeprom: 128 pages of 4 bytes
// [RL3] programmer pulses last at least 250 ns; bench load clock pulses last 40 ns
// [RL4] ready low while busy, high when idle
// [RL5] drive data bus only while enable low
// [RL6] first select: low or high byte
// [RL7] second select: low or extra fuse byte
// [RL8] load clock edge acts on action bits
// [RL9] command byte decoding table
// [RL10] entry: reset low, toggles, pattern 0000
// [RL11] entry fails if pattern moves early
// [RL12] programmer waits 50 us before commanding
// [RL13] command and address kept across operations
// [RL14] reload high address only per window
// [RL15] erase clears memories then locks, keeps fuses
// [RL16] preserve fuse keeps eeprom through erase
// [RL17] write strobe starts operation, drops ready
// [RL18] programmer skips writing erased value
// [RL19] programmer erases before reprogramming
// [RL20] page strobe latches data word into buffer
// [RL21] low address picks word, high bits page
// [RL22] write strobe programs buffered flash page
// [RL23] command zero ends page programming
// [RL24] eeprom page programmed with select low
// [RL25] read flash presents selected byte
// [RL26] pins sampled on load clock rising edge
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH

// ==========================================================
// command codes
`define PPP_CMD_NOP        8'h00
`define PPP_CMD_ERASE      8'h80
`define PPP_CMD_WR_FUSE    8'h40
`define PPP_CMD_WR_LOCK    8'h20
`define PPP_CMD_WR_FLASH   8'h10
`define PPP_CMD_WR_EE      8'h11
`define PPP_CMD_RD_SIG     8'h08
`define PPP_CMD_RD_FUSE    8'h04
`define PPP_CMD_RD_FLASH   8'h02
`define PPP_CMD_RD_EE      8'h03

// ==========================================================
// geometry and field positions
`define PPP_FLASH_WORDS    8192
`define PPP_PAGE_WORDS     64
`define PPP_WORD_BITS      6
`define PPP_FLASH_AW       13
`define PPP_EE_BYTES       512
`define PPP_EE_PAGE        4
`define PPP_EE_AW          9
`define PPP_PRESERVE_BIT   3
`define PPP_ERASED_WORD    16'hFFFF
`define PPP_ERASED_BYTE    8'hFF
`define PPP_LOW_FUSE_RST   8'h62
`define PPP_HIGH_FUSE_RST  8'h99
`define PPP_EXT_FUSE_RST   8'hFF
`define PPP_LOCK_RST       8'hFF
`define PPP_MIN_TOGGLES    6

// ==========================================================
// timing
`define PPP_CLK_PS         5000
`define PPP_CYC_CEIL(ns)   ((((ns) * 1000) + `PPP_CLK_PS - 1) / `PPP_CLK_PS)
`define PPP_ENTRY_WIN_NS   100
`define PPP_ENTRY_WIN_CYC  `PPP_CYC_CEIL(`PPP_ENTRY_WIN_NS)
`define PPP_PROG_TIME_NS   4500
`define PPP_PROG_TIME_CYC  `PPP_CYC_CEIL(`PPP_PROG_TIME_NS)

`endif

// ===== rtl/ppp_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock domain; depth a power of two
`timescale 1ns/1ps
module ppp_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("ppp_fifo: DEPTH must be a power of two >= 2");

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg, wr_ptr_next;
  logic [AW:0]      rd_ptr_reg, rd_ptr_next;
  logic             push, pop;

  always_comb begin
    o_in_ready  = (wr_ptr_reg - rd_ptr_reg) != (AW + 1)'(DEPTH);
    o_out_valid = wr_ptr_reg != rd_ptr_reg;
    o_out_data  = mem[rd_ptr_reg[AW-1:0]];
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_ptr_next = wr_ptr_reg + (AW + 1)'(push);
    rd_ptr_next = rd_ptr_reg + (AW + 1)'(pop);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end
endmodule // ppp_fifo

// ===== rtl/ppp_pkg.sv
// types shared by the parallel programming port modules
// assumes ppp_cfg.svh supplies the numeric constants
package ppp_pkg;

  // ==========================================================
  // synchronised programmer pins
  typedef struct packed {
    logic       prog_voltage;
    logic       output_enable_n;
    logic       write_strobe_n;
    logic       page_load_strobe;
    logic       byte_select_second;
    logic       byte_select_first;
    logic       load_action_bit1;
    logic       load_action_bit0;
    logic       crystal_load_clock;
    logic [7:0] data;
  } ppp_pins_t;

  // one latched word heading for the page buffer
  typedef struct packed {
    logic [5:0]  idx;
    logic [15:0] word;
  } ppp_load_t;

  typedef enum logic [1:0] {ENT_OFF, ENT_WINDOW, ENT_ON, ENT_FAIL} ppp_entry_t;

  typedef enum logic [2:0] {
    OP_IDLE, OP_FL_PROG, OP_EE_PROG, OP_ER_FLASH, OP_ER_EE, OP_ER_LOCK, OP_WAIT
  } ppp_op_t;

endpackage

// ===== rtl/ppp_port.sv
// parallel programming port: entry detection, load decoding, page buffers,
// flash/eeprom arrays, fuse and lock bytes, erase and page programming
// assumes the programmer pins are asynchronous and held >= 250 ns per pulse
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_port import ppp_pkg::*; #(
  parameter int       PROG_CYC   = `PPP_PROG_TIME_CYC,
  parameter int       FIFO_DEPTH = 16,
  parameter bit [7:0] SIG0       = 8'hA5,  // arbitrary identity value
  parameter bit [7:0] SIG1       = 8'h5A,  // arbitrary identity value
  parameter bit [7:0] SIG2       = 8'h3C,  // arbitrary identity value
  parameter bit [7:0] CALIB      = 8'h80   // arbitrary calibration value
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // programmer control pins
  input  wire logic       i_prog_voltage,
  input  wire logic       i_crystal_load_clock,
  input  wire logic       i_load_action_bit0,
  input  wire logic       i_load_action_bit1,
  input  wire logic       i_byte_select_first,
  input  wire logic       i_byte_select_second,
  input  wire logic       i_page_load_strobe,
  input  wire logic       i_write_strobe_n,
  input  wire logic       i_output_enable_n,
  // bidirectional data bus
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  // status
  output logic            o_ready_not_busy,
  output logic            o_prog_mode,
  output logic            o_entry_failed
);
  if (PROG_CYC < 1 || PROG_CYC > 65535) $error("ppp_port: PROG_CYC out of range");

  localparam logic [4:0] WIN_CYC = 5'(`PPP_ENTRY_WIN_CYC);

  // ==========================================================
  // pin synchronisation and edge detection
  ppp_pins_t pins_raw, pins, prev_reg;
  logic      xtal_rise, page_load_strobe_rise, wr_fall, hv_rise, xtal_toggle;
  logic [3:0] pattern;

  assign pins_raw = '{prog_voltage: i_prog_voltage, output_enable_n: i_output_enable_n,
                      write_strobe_n: i_write_strobe_n, page_load_strobe: i_page_load_strobe,
                      byte_select_second: i_byte_select_second,
                      byte_select_first: i_byte_select_first,
                      load_action_bit1: i_load_action_bit1, load_action_bit0: i_load_action_bit0,
                      crystal_load_clock: i_crystal_load_clock, data: i_data};

  ppp_sync #(.WIDTH($bits(ppp_pins_t))) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (pins_raw),
    .o_sync  (pins)
  );

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= pins;
    end
  end

  // data and controls travel the same two flops as the load clock
  always_comb begin
    xtal_rise   = pins.crystal_load_clock && !prev_reg.crystal_load_clock;  // [RL26]
    xtal_toggle = pins.crystal_load_clock != prev_reg.crystal_load_clock;
    page_load_strobe_rise  = pins.page_load_strobe && !prev_reg.page_load_strobe;
    wr_fall     = !pins.write_strobe_n && prev_reg.write_strobe_n;
    hv_rise     = pins.prog_voltage && !prev_reg.prog_voltage;
    pattern     = {pins.page_load_strobe, pins.load_action_bit1, pins.load_action_bit0,
                   pins.byte_select_first};
  end

  // ==========================================================
  // entry into programming mode
  ppp_entry_t ent_reg, ent_next;
  logic [2:0] tog_reg, tog_next;
  logic [4:0] win_reg, win_next;
  logic [3:0] pat_reg, pat_next;

  always_comb begin
    ent_next = ent_reg;
    tog_next = tog_reg;
    win_next = win_reg;
    pat_next = pat_reg;
    case (ent_reg)
      ENT_OFF: begin
        if (xtal_toggle && tog_reg != 3'(`PPP_MIN_TOGGLES)) begin
          tog_next = tog_reg + 3'h1;
        end
        if (hv_rise) begin
          if (tog_reg == 3'(`PPP_MIN_TOGGLES) && pattern == 4'h0) begin
            ent_next = ENT_WINDOW;
            win_next = WIN_CYC;
            pat_next = pattern;
          end else begin
            ent_next = ENT_FAIL;
          end
        end
      end
      ENT_WINDOW: begin
        if (pattern != pat_reg) begin
          ent_next = ENT_FAIL;  // [RL11]
        end else if (win_reg == 5'h1) begin
          ent_next = ENT_ON;
        end
        win_next = win_reg - 5'h1;
      end
      ENT_ON, ENT_FAIL: begin
      end
      default: ent_next = ENT_OFF;
    endcase
    if (!pins.prog_voltage && ent_reg != ENT_OFF) begin
      ent_next = ENT_OFF;
      tog_next = 3'h0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ent_reg <= ENT_OFF;
      tog_reg <= 3'h0;
      win_reg <= 5'h0;
      pat_reg <= 4'h0;
    end else begin
      ent_reg <= ent_next;
      tog_reg <= tog_next;
      win_reg <= win_next;
      pat_reg <= pat_next;
    end
  end

  // ==========================================================
  // load decoding, fuses, locks and operation sequencer
  logic [7:0]  cmd_reg, cmd_next, alo_reg, alo_next, ahi_reg, ahi_next;
  logic [7:0]  dlo_reg, dlo_next, dhi_reg, dhi_next;
  logic [7:0]  fl_reg, fl_next, fh_reg, fh_next, fx_reg, fx_next, lock_reg, lock_next;
  logic        wr_pend_reg, wr_pend_next, pl_pend_reg, pl_pend_next;
  ppp_load_t   pl_word_reg, pl_word_next, drain_word;
  ppp_op_t     op_reg, op_next;
  logic [12:0] idx_reg, idx_next;
  logic [15:0] wait_reg, wait_next;
  logic        nop_clear, in_ready, out_valid, drain_ready;
  logic [12:0] fl_waddr;
  logic [8:0]  ee_waddr;
  logic        fl_we, ee_we, fl_erase, ee_erase;
  logic        active;

  assign active      = ent_reg == ENT_ON;
  assign drain_ready = op_reg == OP_IDLE;  // buffer writes stall while programming

  ppp_fifo #(.WIDTH($bits(ppp_load_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (pl_pend_reg),
    .o_in_ready  (in_ready),
    .i_in_data   (pl_word_reg),
    .o_out_valid (out_valid),
    .i_out_ready (drain_ready),
    .o_out_data  (drain_word)
  );

  always_comb begin
    cmd_next     = cmd_reg;  // [RL13]
    alo_next     = alo_reg;
    ahi_next     = ahi_reg;
    dlo_next     = dlo_reg;
    dhi_next     = dhi_reg;
    fl_next      = fl_reg;
    fh_next      = fh_reg;
    fx_next      = fx_reg;
    lock_next    = lock_reg;
    nop_clear    = 1'b0;
    pl_pend_next = pl_pend_reg && !in_ready;
    pl_word_next = pl_word_reg;
    wr_pend_next = wr_pend_reg;
    op_next      = op_reg;
    idx_next     = idx_reg;
    wait_next    = wait_reg;
    if (active && xtal_rise) begin
      case ({pins.load_action_bit1, pins.load_action_bit0})  // [RL8]
        2'b00: if (pins.byte_select_first) ahi_next = pins.data; else alo_next = pins.data;  // [RL6]
        2'b01: if (pins.byte_select_first) dhi_next = pins.data; else dlo_next = pins.data;
        2'b10: begin
          cmd_next  = pins.data;
          nop_clear = pins.data == `PPP_CMD_NOP;  // [RL23]
        end
        default: ;
      endcase
    end
    if (active && page_load_strobe_rise) begin
      pl_pend_next = 1'b1;  // [RL20]
      pl_word_next = '{idx: alo_reg[5:0], word: {dhi_reg, dlo_reg}};
    end
    case (op_reg)
      OP_IDLE: begin
        if (wr_pend_reg && !out_valid && !pl_pend_reg) begin
          wr_pend_next = 1'b0;
          idx_next     = 13'h0;
          wait_next    = 16'(PROG_CYC);
          case (cmd_reg)  // [RL9]
            `PPP_CMD_ERASE:    op_next = OP_ER_FLASH;  // [RL15]
            `PPP_CMD_WR_FLASH: op_next = OP_FL_PROG;   // [RL22]
            `PPP_CMD_WR_EE:    op_next = pins.byte_select_first ? OP_IDLE : OP_EE_PROG;  // [RL24]
            `PPP_CMD_WR_FUSE: begin
              op_next = OP_WAIT;
              if (pins.byte_select_second) fx_next = dlo_reg;  // [RL7]
              else if (pins.byte_select_first) fh_next = dlo_reg;
              else fl_next = dlo_reg;
            end
            `PPP_CMD_WR_LOCK: begin
              op_next   = OP_WAIT;
              lock_next = lock_reg & dlo_reg;
            end
            default: op_next = OP_IDLE;
          endcase
        end
      end
      OP_FL_PROG: begin
        idx_next = idx_reg + 13'h1;
        if (idx_reg == 13'(`PPP_PAGE_WORDS - 1)) op_next = OP_WAIT;
      end
      OP_EE_PROG: begin
        idx_next = idx_reg + 13'h1;
        if (idx_reg == 13'(`PPP_EE_PAGE - 1)) op_next = OP_WAIT;
      end
      OP_ER_FLASH: begin
        idx_next = idx_reg + 13'h1;
        if (idx_reg == 13'(`PPP_FLASH_WORDS - 1)) begin
          idx_next = 13'h0;
          // programmed means zero
          op_next  = fh_reg[`PPP_PRESERVE_BIT] ? OP_ER_EE : OP_ER_LOCK;  // [RL16]
        end
      end
      OP_ER_EE: begin
        idx_next = idx_reg + 13'h1;
        if (idx_reg == 13'(`PPP_EE_BYTES - 1)) op_next = OP_ER_LOCK;
      end
      OP_ER_LOCK: begin
        lock_next = `PPP_LOCK_RST;  // [RL15]
        op_next   = OP_WAIT;
      end
      OP_WAIT: begin
        wait_next = wait_reg - 16'h1;
        if (wait_reg == 16'h1) op_next = OP_IDLE;
      end
      default: op_next = OP_IDLE;
    endcase
    if (active && wr_fall) begin
      wr_pend_next = 1'b1;  // [RL17]
    end
    if (!active) begin
      wr_pend_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cmd_reg     <= `PPP_CMD_NOP;
      alo_reg     <= 8'h00;
      ahi_reg     <= 8'h00;
      dlo_reg     <= 8'h00;
      dhi_reg     <= 8'h00;
      fl_reg      <= `PPP_LOW_FUSE_RST;
      fh_reg      <= `PPP_HIGH_FUSE_RST;
      fx_reg      <= `PPP_EXT_FUSE_RST;
      lock_reg    <= `PPP_LOCK_RST;
      pl_pend_reg <= 1'b0;
      pl_word_reg <= '0;
      wr_pend_reg <= 1'b0;
      op_reg      <= OP_IDLE;
      idx_reg     <= 13'h0;
      wait_reg    <= 16'h0;
    end else begin
      cmd_reg     <= cmd_next;
      alo_reg     <= alo_next;
      ahi_reg     <= ahi_next;
      dlo_reg     <= dlo_next;
      dhi_reg     <= dhi_next;
      fl_reg      <= fl_next;
      fh_reg      <= fh_next;
      fx_reg      <= fx_next;
      lock_reg    <= lock_next;
      pl_pend_reg <= pl_pend_next;
      pl_word_reg <= pl_word_next;
      wr_pend_reg <= wr_pend_next;
      op_reg      <= op_next;
      idx_reg     <= idx_next;
      wait_reg    <= wait_next;
    end
  end

  // ==========================================================
  // page buffers and memory arrays (no reset: contents only)
  logic [15:0] fl_buf [`PPP_PAGE_WORDS];
  logic [7:0]  ee_buf [`PPP_EE_PAGE];
  logic [15:0] flash_mem [`PPP_FLASH_WORDS];
  logic [7:0]  ee_mem [`PPP_EE_BYTES];

  always_comb begin
    fl_erase = op_reg == OP_ER_FLASH;
    ee_erase = op_reg == OP_ER_EE;
    fl_we    = fl_erase || op_reg == OP_FL_PROG;
    ee_we    = ee_erase || op_reg == OP_EE_PROG;
    // page bits from both address bytes, word bits from the sequencer
    fl_waddr = fl_erase ? idx_reg
             : {ahi_reg[4:0], alo_reg[7:`PPP_WORD_BITS], idx_reg[5:0]};  // [RL1] [RL21]
    ee_waddr = ee_erase ? idx_reg[8:0] : {ahi_reg[0], alo_reg[7:2], idx_reg[1:0]};  // [RL2]
  end

  always_ff @(posedge i_clk) begin
    if (nop_clear) begin
      for (int i = 0; i < `PPP_PAGE_WORDS; i++) fl_buf[i] <= `PPP_ERASED_WORD;
      for (int i = 0; i < `PPP_EE_PAGE; i++) ee_buf[i] <= `PPP_ERASED_BYTE;
    end else if (out_valid && drain_ready) begin
      if (cmd_reg == `PPP_CMD_WR_EE) ee_buf[drain_word.idx[1:0]] <= drain_word.word[7:0];
      else fl_buf[drain_word.idx] <= drain_word.word;  // [RL20]
    end
    if (fl_we) flash_mem[fl_waddr] <= fl_erase ? `PPP_ERASED_WORD : fl_buf[idx_reg[5:0]];
    if (ee_we) ee_mem[ee_waddr] <= ee_erase ? `PPP_ERASED_BYTE : ee_buf[idx_reg[1:0]];
  end

  // ==========================================================
  // read path and status outputs
  logic [7:0]  rd_next;
  logic [15:0] fl_word;

  always_comb begin
    fl_word = flash_mem[{ahi_reg[4:0], alo_reg}];
    case (cmd_reg)
      `PPP_CMD_RD_FLASH: rd_next = pins.byte_select_first ? fl_word[15:8] : fl_word[7:0];  // [RL25]
      `PPP_CMD_RD_EE:    rd_next = ee_mem[{ahi_reg[0], alo_reg}];
      `PPP_CMD_RD_SIG: begin
        if (pins.byte_select_first) rd_next = CALIB;
        else if (alo_reg[1:0] == 2'h0) rd_next = SIG0;
        else if (alo_reg[1:0] == 2'h1) rd_next = SIG1;
        else rd_next = SIG2;
      end
      `PPP_CMD_RD_FUSE: begin
        case ({pins.byte_select_second, pins.byte_select_first})  // [RL7]
          2'b00:   rd_next = fl_reg;
          2'b11:   rd_next = fh_reg;
          2'b10:   rd_next = fx_reg;
          default: rd_next = lock_reg;
        endcase
      end
      default: rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_data           <= 8'h00;
      o_data_oe        <= 1'b0;
      o_ready_not_busy <= 1'b0;
      o_prog_mode      <= 1'b0;
      o_entry_failed   <= 1'b0;
    end else begin
      o_data           <= rd_next;
      o_data_oe        <= active && !pins.output_enable_n;  // [RL5]
      o_ready_not_busy <= active && op_next == OP_IDLE && !wr_pend_next;  // [RL4] [RL17]
      o_prog_mode      <= active;
      o_entry_failed   <= ent_reg == ENT_FAIL;
    end
  end
endmodule // ppp_port

// ===== rtl/ppp_sync.sv
// two-flop synchroniser bank for the programmer pins
// assumes inputs are asynchronous to i_clk
`timescale 1ns/1ps
module ppp_sync #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // pins
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  if (WIDTH < 1) $error("ppp_sync: WIDTH must be positive");

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // ppp_sync

// ===== tb/ppp_port_chk.sv
// checker: port-level timing relations of the programming port
// assumes it is bound to ppp_port and sees only that module's ports
`timescale 1ns/1ps
module ppp_port_chk #(
  parameter int PROG_CYC = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // programmer pins
  input wire logic i_prog_voltage,
  input wire logic i_write_strobe_n,
  input wire logic i_output_enable_n,
  // device outputs
  input wire logic o_data_oe,
  input wire logic o_ready_not_busy,
  input wire logic o_prog_mode,
  input wire logic o_entry_failed
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  // ==========================================================
  // busy length counter
  int busy_reg;
  int busy_next;
  always_comb busy_next = o_ready_not_busy ? 0 : busy_reg + 1;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) busy_reg <= 0;
    else busy_reg <= busy_next;
  end

  // ==========================================================
  // properties
  // pin passes sync plus register, so six idle samples are ample
  property p_oe_off; i_output_enable_n [*6] |-> !o_data_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus driven with enable high");
  property p_oe_on; (!i_output_enable_n && o_prog_mode) [*6] |-> o_data_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus not driven with enable low");
  property p_oe_mode; o_data_oe |-> o_prog_mode; endproperty
  a_oe_mode: assert property (p_oe_mode) else $error("bus driven outside mode");
  property p_wr_busy; $fell(i_write_strobe_n) && o_ready_not_busy && o_prog_mode |-> ##[1:6] !o_ready_not_busy;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write strobe left ready high");
  property p_busy_len; $rose(o_ready_not_busy) |-> busy_reg >= PROG_CYC; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy period too short");
  property p_mode_excl; !(o_prog_mode && o_entry_failed); endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("mode and failure together");
  property p_mode_rise; $rose(o_prog_mode) |-> $past(i_prog_voltage, 20); endproperty
  a_mode_rise: assert property (p_mode_rise) else $error("mode entered before window");
  property p_mode_drop; !i_prog_voltage [*6] |-> !o_prog_mode && !o_entry_failed; endproperty
  a_mode_drop: assert property (p_mode_drop) else $error("mode held without voltage");
endmodule // ppp_port_chk

bind ppp_port ppp_port_chk #(.PROG_CYC(PROG_CYC)) ppp_port_chk_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_prog_voltage(i_prog_voltage),
  .i_write_strobe_n(i_write_strobe_n), .i_output_enable_n(i_output_enable_n),
  .o_data_oe(o_data_oe), .o_ready_not_busy(o_ready_not_busy),
  .o_prog_mode(o_prog_mode), .o_entry_failed(o_entry_failed));

// ===== tb/ppp_prog_bus.sv
// programmer side of the shared data bus
// assumes one driver at a time; a floating bus shows the inverse of its last value
`timescale 1ns/1ps
module ppp_prog_bus (
  // clock
  input  wire logic       i_clk,
  // device and programmer drives
  input  wire logic       i_dev_oe,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_host_en,
  input  wire logic [7:0] i_host_data,
  // resolved bus
  output logic      [7:0] o_bus
);
  logic [7:0] last_reg;
  always_ff @(posedge i_clk) begin
    if (i_dev_oe || i_host_en) last_reg <= o_bus;
  end
  // no pull on the bus, so a stale value must not read as valid
  always_comb o_bus = i_dev_oe ? i_dev_data : (i_host_en ? i_host_data : ~last_reg);
endmodule // ppp_prog_bus

// ===== tb/tb.sv
// bench: entry, erase, flash and eeprom pages, fuses, locks, signature
// assumes ppp_port, ppp_prog_bus and the bound checker are compiled first
`timescale 1ns/1ps
module tb;
  localparam int PC = 4;
  localparam bit [7:0] SIG = 8'hC3; // arbitrary identity value
  localparam bit [7:0] CAL = 8'h47; // arbitrary calibration value
  typedef struct packed {logic [1:0] k; logic [7:0] e;} ppp_note_t;
  logic       i_clk = 0, i_reset = 1, vpp = 0, xtal = 0, a0 = 0, a1 = 0;
  logic       bs1 = 0, bs2 = 0, pl = 0, wr_n = 1, oe_n = 1, drv_en = 0, look = 0;
  logic [7:0] drv = 8'h00, bus, o_data;
  logic       oe, rdy, mode, fail;
  int         n_fail = 0, samples_checked = 0;
  ppp_note_t  notes[$];

  ppp_port #(.PROG_CYC(PC), .SIG0(SIG), .CALIB(CAL)) ppp_port_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_prog_voltage(vpp), .i_crystal_load_clock(xtal),
    .i_load_action_bit0(a0), .i_load_action_bit1(a1), .i_byte_select_first(bs1),
    .i_byte_select_second(bs2), .i_page_load_strobe(pl), .i_write_strobe_n(wr_n),
    .i_output_enable_n(oe_n), .i_data(bus), .o_data(o_data), .o_data_oe(oe),
    .o_ready_not_busy(rdy), .o_prog_mode(mode), .o_entry_failed(fail));
  ppp_prog_bus ppp_prog_bus_inst (.i_clk(i_clk), .i_dev_oe(oe), .i_dev_data(o_data),
    .i_host_en(drv_en), .i_host_data(drv), .o_bus(bus));
  initial forever #2.5 i_clk = ~i_clk;

  // ==========================================================
  // shared tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input logic [1:0] k, input logic [7:0] e);
    cyc(1);
    notes.push_back({k, e});
    look = 1;
    cyc(1);
    look = 0;
  endtask
  // load clock runs at 80 ns, inside a load and in the entry toggles
  task automatic xt();
    xtal = 1;
    #40;
    xtal = 0;
    #40;
  endtask
  task automatic ld(input logic [1:0] act, input logic b, input logic [7:0] d);
    cyc(1);
    {a1, a0} = act;
    bs1 = b;
    drv = d;
    drv_en = 1;
    cyc(14);
    xt();
    cyc(14);
    drv_en = 0;
    {a1, a0} = 2'h3;
  endtask
  task automatic pulse_wr();
    wr_n = 0;
    cyc(50);
    wr_n = 1;
  endtask
  task automatic pulse_pl();
    pl = 1;
    cyc(50);
    pl = 0;
  endtask
  task automatic wait_rdy();
    int i;
    for (i = 0; i < 20000 && rdy !== 1'b1; i++) cyc(1);
    if (i == 20000) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic b1, input logic b2, input logic [7:0] e);
    bs1 = b1;
    bs2 = b2;
    oe_n = 0;
    cyc(8);
    chk(2'h0, e);
    oe_n = 1;
    cyc(8);
  endtask

  // ==========================================================
  // result watcher
  always @(posedge i_clk) begin
    ppp_note_t n;
    if (look) begin
      n = notes.pop_front();
      case (n.k)
        2'h0: check("bus", bus, n.e);
        2'h1: check("status", {5'h00, fail, mode, rdy}, n.e);
        default: check("drive enable", {7'h00, oe}, n.e);
      endcase
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] w[4];
    logic [5:0]  ix[4];
    logic [6:0]  p, e;
    logic [7:0]  eb[4];
    void'($urandom(66555));
    p = 7'($urandom);
    e = 7'($urandom);
    ix = '{6'h00, 6'h3F, 6'($urandom_range(62, 2)), 6'h01};
    foreach (w[i]) w[i] = 16'($urandom);
    w[3] = 16'hFFFF;
    foreach (eb[i]) eb[i] = 8'($urandom);
    cyc(12);
    i_reset = 0;
    chk(2'h1, 8'h00);
    // pattern change in window spoils entry
    repeat (3) xt();
    cyc(20);
    vpp = 1;
    cyc(5);
    pl = 1;
    cyc(40);
    chk(2'h1, 8'h04);
    pl = 0;
    vpp = 0;
    cyc(10);
    repeat (3) xt();
    cyc(20);
    vpp = 1;
    cyc(40);
    chk(2'h1, 8'h03);
    cyc(10000);
    ld(2'h2, 0, 8'h80);
    pulse_wr();
    chk(2'h1, 8'h02);
    wait_rdy();
    ld(2'h2, 0, 8'h00);
    ld(2'h2, 0, 8'h10);
    for (int i = 0; i < 3; i++) begin
      ld(2'h0, 0, {p[1:0], ix[i]});
      ld(2'h1, 0, w[i][7:0]);
      ld(2'h1, 1, w[i][15:8]);
      pulse_pl();
    end
    ld(2'h0, 1, {3'h0, p[6:2]});
    pulse_wr();
    wait_rdy();
    ld(2'h2, 0, 8'h00);
    ld(2'h2, 0, 8'h02);
    for (int i = 0; i < 4; i++) begin
      ld(2'h0, 0, {p[1:0], ix[i]});
      rd(0, 0, w[i][7:0]);
      rd(1, 0, w[i][15:8]);
    end
    chk(2'h2, 8'h00);
    ld(2'h2, 0, 8'h11);
    for (int j = 0; j < 4; j++) begin
      ld(2'h0, 0, {e[5:0], 2'(j)});
      ld(2'h1, 0, eb[j]);
      pulse_pl();
    end
    ld(2'h0, 1, {7'h00, e[6]});
    bs1 = 0;
    pulse_wr();
    wait_rdy();
    ld(2'h2, 0, 8'h03);
    for (int j = 0; j < 4; j++) begin
      ld(2'h0, 0, {e[5:0], 2'(j)});
      rd(0, 0, eb[j]);
    end
    ld(2'h2, 0, 8'h08);
    ld(2'h0, 0, 8'h00);
    rd(0, 0, SIG);
    rd(1, 0, CAL);
    // high fuse with the preserve bit programmed
    ld(2'h2, 0, 8'h40);
    ld(2'h1, 0, 8'h91);
    bs1 = 1;
    pulse_wr();
    wait_rdy();
    ld(2'h2, 0, 8'h20);
    ld(2'h1, 0, 8'hFC);
    pulse_wr();
    wait_rdy();
    ld(2'h2, 0, 8'h04);
    rd(0, 0, 8'h62);
    rd(1, 1, 8'h91);
    rd(0, 1, 8'hFF);
    rd(1, 0, 8'hFC);
    ld(2'h2, 0, 8'h80);
    pulse_wr();
    wait_rdy();
    ld(2'h2, 0, 8'h04);
    rd(1, 1, 8'h91);
    rd(1, 0, 8'hFF);
    ld(2'h2, 0, 8'h03);
    ld(2'h0, 0, {e[5:0], 2'h0});
    rd(0, 0, eb[0]);
    ld(2'h2, 0, 8'h02);
    ld(2'h0, 1, {3'h0, p[6:2]});
    ld(2'h0, 0, {p[1:0], ix[0]});
    rd(1, 0, 8'hFF);
    cyc(20);
    report_and_stop();
  end
endmodule // tb
